// ### inc/dec_pkg.sv
// Package with register map, field layout and types of the dual edge capture pair.
package dec_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] DEC_CTRL_OFS = 8'h00;
  localparam logic [7:0] DEC_STAT_OFS = 8'h04;
  localparam logic [7:0] DEC_VAL1_OFS = 8'h08;
  localparam logic [7:0] DEC_VAL2_OFS = 8'h0c;
  localparam logic [7:0] DEC_CNT_OFS = 8'h10;

  // Control register field positions.
  localparam int DEC_CTRL_EN_BIT = 0;
  localparam int DEC_CTRL_ARM_BIT = 1;
  localparam int DEC_CTRL_REP_BIT = 2;
  localparam int DEC_CTRL_FILT_BIT = 3;
  localparam int DEC_CTRL_ES1_LSB = 4;
  localparam int DEC_CTRL_ES2_LSB = 6;
  localparam int DEC_CTRL_IE1_BIT = 8;
  localparam int DEC_CTRL_IE2_BIT = 9;

  // Status register field positions; write one to clear.
  localparam int DEC_STAT_F1_BIT = 0;
  localparam int DEC_STAT_F2_BIT = 1;

  // Edge select encodings; zero means the pin is not used.
  localparam logic [1:0] DEC_EDGE_OFF = 2'h0;
  localparam logic [1:0] DEC_EDGE_RISE = 2'h1;
  localparam logic [1:0] DEC_EDGE_FALL = 2'h2;

  // Values after reset.
  localparam logic [31:0] DEC_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] DEC_CNT_RST = 16'h0000;

  // Filter settles after this many equal samples.
  localparam int DEC_FILT_CYCLES = 4;

  // Control bits that steer the pair.
  typedef struct packed {
    logic irq2_en;
    logic irq1_en;
    logic [1:0] second_edge_select;
    logic [1:0] first_edge_select;
    logic filter_en;
    logic capture_repeat_select;
    logic capture_arm;
    logic pair_dual_capture_enable;
  } dec_ctrl_t;

  // Edge events from the shared detector.
  typedef struct packed {
    logic rise;
    logic fall;
  } dec_edge_t;

  // Capture sequence states.
  typedef enum logic [2:0] {
    DEC_IDLE = 3'b001,
    DEC_WAIT1 = 3'b010,
    DEC_WAIT2 = 3'b100
  } dec_state_t;

endpackage : dec_pkg

// ### rtl/dec_edge_det.sv
// Shared edge detector with an optional glitch filter on the first channel input.
`timescale 1ns/10ps
module dec_edge_det
  import dec_pkg::*;
#(
  parameter int FILT_LEN = DEC_FILT_CYCLES,
  parameter bit FILT_OK = 1'b1
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Input and control.
  input wire logic i_pin,
  input wire logic i_filt_en,
  // Edge events, one cycle each.
  output dec_edge_t o_edge
);

  logic [$clog2(FILT_LEN+1)-1:0] cnt_q;
  logic filt_q;
  logic last_q;
  logic use_filt;

  // The filter only exists on the pairs that allow it.
  assign use_filt = i_filt_en & FILT_OK;

  // Filter counts samples that differ from the held level before accepting them.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (!use_filt || i_pin == filt_q) begin
      cnt_q <= '0;
      filt_q <= i_pin;
    end else if (cnt_q == ($clog2(FILT_LEN+1))'(FILT_LEN - 1)) begin
      cnt_q <= '0;
      filt_q <= i_pin;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // One detector feeds both capture stages.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_q <= 1'b0;
      o_edge <= '0;
    end else begin
      last_q <= filt_q;
      o_edge.rise <= filt_q & ~last_q;
      o_edge.fall <= ~filt_q & last_q;
    end
  end

endmodule : dec_edge_det

// ### rtl/dec_pair.sv
// Dual edge capture logic for one timer channel pair with an APB register port.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps

// How it works
// - Dual capture runs only while pair_dual_capture_enable is one.
// - Input filter allowed only on pairs whose first channel index is 0 or 2.
// - Repeat select one gives continuous capture, otherwise one-shot.
// - Equal edge selects measure a period, different ones a pulse width.
// - Both edges come from the first input; second input ignored.
// - First edge sets first flag and its interrupt when enabled.
// - Second edge sets second flag only when first flag already set.
// - Counter latched on first edge into value one, second edge into value two.
// - Pair stays coherent if software reads value one before value two.
// - Captures happen only while armed; continuous repeats while armed.
// - Continuous values keep latest pair, readable after disarming.
// - Continuous allows clearing only second flag; next set means new pair.
// - Rise then fall gives positive width, fall then rise negative width.
// - One-shot second edge sets second flag and clears the arm bit.
// - Both rise measures rising period, both fall falling period.
// - Second count buffered, moved to value two when value one is read.
// - Reset clears counter, flags, and leaves pins uncontrolled.
module dec_pair
  import dec_pkg::*;
#(
  parameter int PAIR_INDEX = 0,
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Channel inputs; the second one is not used in this mode.
  input wire logic i_ch1_in,
  input wire logic i_ch2_in,
  // Channel interrupts.
  output logic o_irq1,
  output logic o_irq2
);

  logic rst1_q;
  logic rst_n_q;
  dec_ctrl_t ctrl_q;
  logic [CNT_W-1:0] cnt_q;
  logic f1_q;
  logic f2_q;
  logic [CNT_W-1:0] val1_q;
  logic [CNT_W-1:0] val2_q;
  logic [CNT_W-1:0] buf1_q;
  logic [CNT_W-1:0] buf2_q;
  dec_state_t state_q;
  dec_edge_t edge_ev;
  logic unused_in;
  logic access;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_val1;
  logic hit1;
  logic hit2;
  logic active;
  logic take1;
  logic take2;
  logic disarm;
  logic clr1;
  logic clr2;

  // Reset release through two flip-flops.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst_n_q <= rst1_q;
    end
  end

  // The second input is deliberately left unread in dual capture.
  assign unused_in = i_ch2_in;

  // Edge detection on the first input only.
  dec_edge_det #(
    .FILT_LEN(DEC_FILT_CYCLES),
    .FILT_OK((PAIR_INDEX == 0) || (PAIR_INDEX == 2))
  ) u_edge (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n_q),
    .i_pin(i_ch1_in),
    .i_filt_en(ctrl_q.filter_en),
    .o_edge(edge_ev)
  );

  // APB decode; value two is loaded on the same edge that samples value one's read data.
  assign access = i_psel & i_penable;
  assign wr_ctrl = access & i_pwrite & (i_paddr == DEC_CTRL_OFS);
  assign wr_stat = access & i_pwrite & (i_paddr == DEC_STAT_OFS);
  assign rd_val1 = i_psel & ~i_penable & ~i_pwrite & (i_paddr == DEC_VAL1_OFS);
  assign clr1 = wr_stat & i_pwdata[DEC_STAT_F1_BIT];
  assign clr2 = wr_stat & i_pwdata[DEC_STAT_F2_BIT];

  // Edge matching against each stage's selection; equal selections give period, else width.
  always_comb begin
    hit1 = 1'b0;
    hit2 = 1'b0;
    case (ctrl_q.first_edge_select)
      DEC_EDGE_RISE: hit1 = edge_ev.rise;
      DEC_EDGE_FALL: hit1 = edge_ev.fall;
      default: hit1 = 1'b0;
    endcase
    case (ctrl_q.second_edge_select)
      DEC_EDGE_RISE: hit2 = edge_ev.rise;
      DEC_EDGE_FALL: hit2 = edge_ev.fall;
      default: hit2 = 1'b0;
    endcase
  end

  // Captures are live only while enabled and armed.
  assign active = ctrl_q.pair_dual_capture_enable & ctrl_q.capture_arm;

  // Sequencing: a second edge counts only once the first flag is up.
  always_comb begin
    take1 = 1'b0;
    take2 = 1'b0;
    case (state_q)
      DEC_IDLE: begin
        take1 = 1'b0;
      end
      DEC_WAIT1: begin
        take1 = active & hit1;
      end
      DEC_WAIT2: begin
        take2 = active & hit2 & f1_q;
        take1 = active & hit1 & ~take2 & ctrl_q.capture_repeat_select;
      end
      default: begin
        take1 = 1'b0;
      end
    endcase
  end

  // One-shot finishes with the second edge and drops the arm bit.
  assign disarm = take2 & ~ctrl_q.capture_repeat_select;

  // State walks from the first edge to the second and, in continuous style, round again.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= DEC_IDLE;
    end else begin
      case (state_q)
        DEC_IDLE: begin
          if (active) begin
            state_q <= f1_q ? DEC_WAIT2 : DEC_WAIT1;
          end
        end
        DEC_WAIT1: begin
          if (!active) begin
            state_q <= DEC_IDLE;
          end else if (take1) begin
            state_q <= DEC_WAIT2;
          end
        end
        DEC_WAIT2: begin
          if (!active || disarm) begin
            state_q <= DEC_IDLE;
          end else if (take2) begin
            state_q <= DEC_WAIT1;
          end else if (!f1_q) begin
            state_q <= DEC_WAIT1;
          end
        end
        default: begin
          state_q <= DEC_IDLE;
        end
      endcase
    end
  end

  // Control register; hardware clears the arm bit on one-shot completion.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= dec_ctrl_t'(DEC_CTRL_RST[9:0]);
    end else if (disarm) begin
      ctrl_q <= wr_ctrl ? dec_ctrl_t'(i_pwdata[9:0]) : ctrl_q;
      ctrl_q.capture_arm <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q <= dec_ctrl_t'(i_pwdata[9:0]);
    end
  end

  // Free-running counter that the captures sample.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= CNT_W'(DEC_CNT_RST);
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Edge flags: a set in the same cycle as a clear wins.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      f1_q <= 1'b0;
      f2_q <= 1'b0;
    end else begin
      if (take1) begin
        f1_q <= 1'b1;
      end else if (clr1) begin
        f1_q <= 1'b0;
      end
      if (take2) begin
        f2_q <= 1'b1;
      end else if (clr2) begin
        f2_q <= 1'b0;
      end
    end
  end

  // Capture buffers; value one gets its buffer when the pair completes.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      buf1_q <= '0;
      buf2_q <= '0;
      val1_q <= '0;
    end else begin
      if (take1) begin
        buf1_q <= cnt_q;
      end
      if (take2) begin
        buf2_q <= cnt_q;
        val1_q <= take1 ? cnt_q : buf1_q;
      end
    end
  end

  // Value two is loaded from its buffer only on a read of value one.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      val2_q <= '0;
    end else if (rd_val1) begin
      val2_q <= take2 ? cnt_q : buf2_q;
    end
  end

  // Read data, ready and error; unmapped addresses answer with an error.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      if (i_psel & ~i_penable) begin
        case (i_paddr)
          DEC_CTRL_OFS: o_prdata <= {22'h0, ctrl_q};
          DEC_STAT_OFS: o_prdata <= {30'h0, f2_q, f1_q};
          DEC_VAL1_OFS: o_prdata <= 32'(take2 ? buf1_q : val1_q);
          DEC_VAL2_OFS: o_prdata <= 32'(val2_q);
          DEC_CNT_OFS: o_prdata <= 32'(cnt_q);
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Interrupts follow flag and enable.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_irq1 <= 1'b0;
      o_irq2 <= 1'b0;
    end else begin
      o_irq1 <= (f1_q | take1) & ctrl_q.irq1_en;
      o_irq2 <= (f2_q | take2) & ctrl_q.irq2_en;
    end
  end

endmodule : dec_pair

// ### verif/dec_pair_sva.sv
// Port checker for the dual edge capture pair.
`timescale 1ns/10ps
module dec_pair_sva
  import dec_pkg::*;
(
  // Clock, reset and bus.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Pin and interrupts.
  input wire logic i_ch1_in,
  input wire logic o_irq1,
  input wire logic o_irq2
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  dec_ctrl_t ctl_q;
  logic pin_q;
  logic [7:0] pq_q, wq_q;
  logic wr;
  // A write access that the slave accepts.
  assign wr = i_psel && i_penable && i_pwrite && o_pready;
  // Control shadow and cycles since the last pin change or write.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q <= '0;
      pin_q <= 1'b0;
      pq_q <= 8'h00;
      wq_q <= 8'h00;
    end else begin
      pin_q <= i_ch1_in;
      if (wr && i_paddr == DEC_CTRL_OFS) ctl_q <= dec_ctrl_t'(i_pwdata[9:0]);
      pq_q <= (wr || i_ch1_in != pin_q) ? 8'h00 : pq_q + {7'h00, pq_q != 8'hff};
      wq_q <= wr ? 8'h00 : wq_q + {7'h00, wq_q != 8'hff};
    end
  end
  // Bus phases.
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable && o_pready;
  endsequence
  a_zero_wait: assert property (s_setup |=> s_access)
    else $error("ready missing in access cycle");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_refused_read: assert property (o_pslverr && !i_pwrite |-> o_pready && o_prdata == 32'h0)
    else $error("refused read not zero");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_irq1 && !o_irq2 && !o_pready)
    else $error("output active after reset");
  a_irq1_gate: assert property ($rose(o_irq1) |-> ctl_q.irq1_en && ctl_q.pair_dual_capture_enable)
    else $error("first interrupt while off");
  a_irq2_gate: assert property ($rose(o_irq2) |-> ctl_q.irq2_en && ctl_q.pair_dual_capture_enable)
    else $error("second interrupt while off");
  a_irq1_cause: assert property ($rose(o_irq1) |-> pq_q < 8'd14)
    else $error("first interrupt without edge");
  a_irq2_order: assert property ($rose(o_irq2) |-> o_irq1 || !ctl_q.irq1_en)
    else $error("second flag before first");
  a_irq1_hold: assert property ($fell(o_irq1) |-> wq_q < 8'd4)
    else $error("first interrupt dropped alone");
endmodule : dec_pair_sva

bind dec_pair dec_pair_sva dec_pair_sva_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ch1_in(i_ch1_in), .o_irq1(o_irq1), .o_irq2(o_irq2));

// ### verif/dec_sig_model.sv
// Source of the measured signal and of noise on the unused input.
`timescale 1ns/10ps
module dec_sig_model (
  // Clock and control.
  input wire logic i_mclk,
  input wire logic i_run,
  input wire logic [7:0] i_hi,
  input wire logic [7:0] i_lo,
  // Signal and noise.
  output logic o_sig,
  output logic o_noise
);
  logic [7:0] cnt_q;
  initial begin
    o_sig = 1'b0;
    o_noise = 1'b0;
    cnt_q = 8'h01;
  end
  // Square wave while running, parked low when stopped; noise toggles always.
  always @(posedge i_mclk) begin
    o_noise <= ~o_noise;
    if (!i_run || cnt_q == (o_sig ? i_hi : i_lo)) begin
      o_sig <= i_run ? ~o_sig : 1'b0;
      cnt_q <= 8'h01;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : dec_sig_model

// ### verif/tb_top.sv
// Self-checking bench for the dual edge capture pair.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_errors++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  import dec_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m;} dec_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic run = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] hi = 8'h06;
  logic [7:0] lo = 8'h06;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, v;
  logic rdy, err, ch1, ch2, irq1, irq2;
  int n_errors = 0;
  int checks = 0;
  dec_note_t q[$];
  dec_note_t nt;
  dec_pair dec_pair_i (.i_mclk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err),
    .i_ch1_in(ch1), .i_ch2_in(ch2), .o_irq1(irq1), .o_irq2(irq2));
  dec_sig_model dec_sig_model_i (.i_mclk(clk), .i_run(run), .i_hi(hi), .i_lo(lo), .o_sig(ch1), .o_noise(ch2));
  // Clock of 40 ns.
  initial begin
    forever #20 clk = ~clk;
  end
  // One bus transfer; a read notes its expected value and mask.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] m,
      output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    addr <= a;
    pwr <= w;
    wdat <= w ? d : $urandom;
    if (!w) q.push_back('{d, m});
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rdat;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Waits a bounded time for the second interrupt.
  task automatic wait_irq2();
    int n;
    n = 0;
    while (irq2 !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_irq2
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Checks the error of each completed access and compares each read with the oldest note.
  always @(posedge clk) begin
    if (psel && pen && rdy) begin
      `CHK("slverr", addr > DEC_CNT_OFS, err)
      if (!pwr) begin
        nt = q.pop_front();
        `CHK("prdata", nt.e & nt.m, rdat & nt.m)
      end
    end
  end
  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  // Main sequence.
  initial begin
    logic [31:0] ctl, w;
    void'($urandom(32'h460f));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("irq", 2'b00, {irq1, irq2})
    apb(DEC_CTRL_OFS, 0, DEC_CTRL_RST, '1, v);
    apb(DEC_STAT_OFS, 0, 0, '1, v);
    apb(8'h14, 1, 32'h3ff, 0, v);
    apb(8'h14, 0, 0, '1, v);
    // Armed but not enabled: nothing is captured.
    apb(DEC_CTRL_OFS, 1, 32'h392, 0, v);
    run <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK("irq", 2'b00, {irq1, irq2})
    apb(DEC_STAT_OFS, 0, 0, '1, v);
    // One-shot for each pair of edge selections.
    for (int i = 0; i < 4; i++) begin
      hi <= 8'd6 + 8'($urandom % 20);
      lo <= 8'd6 + 8'($urandom % 20);
      run <= 1'b0;
      repeat (8) @(posedge clk);
      apb(DEC_STAT_OFS, 1, 32'h3, 0, v);
      ctl = {22'h0, 2'b11, i[0] ? DEC_EDGE_FALL : DEC_EDGE_RISE, i[1] ? DEC_EDGE_FALL : DEC_EDGE_RISE,
        1'($urandom), 3'b011};
      w = (i % 3 == 0) ? {24'h0, hi} + {24'h0, lo} : (i == 1 ? {24'h0, hi} : {24'h0, lo});
      apb(DEC_CTRL_OFS, 1, ctl, 0, v);
      run <= 1'b1;
      wait_irq2();
      `CHK("irq", 2'b11, {irq1, irq2})
      apb(DEC_CTRL_OFS, 0, ctl & ~32'h2, '1, v);
      apb(DEC_VAL1_OFS, 0, 0, 0, v);
      apb(DEC_VAL2_OFS, 0, v + w, 32'hffff, v);
      apb(DEC_VAL2_OFS, 0, v, 32'hffff, v);
    end
    // Continuous pulse width, clearing only the second flag.
    hi <= 8'd9;
    lo <= 8'd20;
    run <= 1'b0;
    apb(DEC_STAT_OFS, 1, 32'h3, 0, v);
    apb(DEC_CTRL_OFS, 1, 32'h397, 0, v);
    run <= 1'b1;
    repeat (2) begin
      wait_irq2();
      `CHK("irq", 2'b11, {irq1, irq2})
      apb(DEC_STAT_OFS, 1, 32'h2, 0, v);
      apb(DEC_STAT_OFS, 0, 1, '1, v);
    end
    apb(DEC_CTRL_OFS, 1, 32'h395, 0, v);
    run <= 1'b0;
    apb(DEC_VAL1_OFS, 0, 0, 0, v);
    apb(DEC_VAL2_OFS, 0, v + 32'd9, 32'hffff, v);
    // A reset after disarming and stopping the signal, with the first flag still up, clears flags, interrupts and control.
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("irq", 2'b00, {irq1, irq2})
    apb(DEC_STAT_OFS, 0, 0, '1, v);
    apb(DEC_CTRL_OFS, 0, DEC_CTRL_RST, '1, v);
    stop_test();
  end
endmodule : tb_top
